// [hdl/ussc_defs.svh]
// Register indices, field positions and reset values of the serial shift core
`ifndef USSC_DEFS_SVH
`define USSC_DEFS_SVH
// Register indices; the APB byte address is four times the index
`define USSC_IDX_CTRL 8'h0d
`define USSC_IDX_STAT 8'h0e
`define USSC_IDX_DATA 8'h0f
`define USSC_IDX_BUF 8'h10
`define USSC_IDX_PORT 8'h11
// Control register fields
`define USSC_CTRL_SIE 7
`define USSC_CTRL_OIE 6
`define USSC_CTRL_WM_HI 5
`define USSC_CTRL_WM_LO 4
`define USSC_CTRL_CS1 3
`define USSC_CTRL_CS0 2
`define USSC_CTRL_CLK 1
`define USSC_CTRL_TC 0
// Status register fields
`define USSC_STAT_SIF 7
`define USSC_STAT_OIF 6
`define USSC_STAT_PF 5
`define USSC_STAT_DC 4
`define USSC_STAT_CNT_HI 3
// Port control register fields
`define USSC_PORT_GIE 6
`define USSC_PORT_DO_DIR 5
`define USSC_PORT_SDA_DIR 4
`define USSC_PORT_SCL_DIR 3
`define USSC_PORT_DO_OUT 2
`define USSC_PORT_SDA_OUT 1
`define USSC_PORT_SCL_OUT 0
// Reset values
`define USSC_RST_CTRL 8'h00
`define USSC_RST_STAT 8'h00
`define USSC_RST_DATA 8'h00
`define USSC_RST_PORT 8'h07
`define USSC_CNT_MAX 4'hf
`endif

// [hdl/ussc_pkg.sv]
// Types shared by the serial shift core
package ussc_pkg;
    // Wire mode encodings in field order
    typedef enum logic [1:0] {
        USSC_WM_OFF,
        USSC_WM_THREE,
        USSC_WM_TWO,
        USSC_WM_TWO_HOLD
    } ussc_wm_t;

    // Stored control fields
    typedef struct packed {
        logic start_irq_enable;
        logic overflow_irq_enable;
        ussc_wm_t wire_mode_select;
        logic [1:0] clock_source_select;
    } ussc_ctrl_t;

    // Port direction and output bits
    typedef struct packed {
        logic gie;
        logic do_dir;
        logic sda_dir;
        logic scl_dir;
        logic do_out;
        logic sda_out;
        logic scl_out;
    } ussc_port_t;
endpackage

// [hdl/ussc_core.sv]
// Universal serial shift core: APB registers, shifter, counter, line detectors
`timescale 1ns/10ps
`include "ussc_defs.svh"

// What this block does
// - Start condition detector works only in the two-wire modes.
// - Start detection needs no CPU activity and can wake from power-down.
// - Two-wire slave holds the clock line low until ready for more data.
// - External clock: counter increments on both rising and falling edges.
// - Data register shifts left on each clock of the selected source.
// - CPU write and shift in one cycle: the written value wins.
// - Data and clock inputs feed shifter and counter even with outputs off.
// - MSB drives output through latch, open first half-cycle or always if internal.
// - Writing a new MSB while the latch is open changes the pin at once.
// - Serial data reaches the pin only when its direction bit is output.
// - On overflow the data register is copied into the completion buffer.
// - Start flag: start condition in two-wire, any clock edge otherwise.
// - Start flag clears by writing one, releasing the start clock hold.
// - Enabled start interrupt wakes the processor from every sleep mode.
// - Overflow flag sets on wrap 15 to 0, write-one clears and releases hold.
// - Overflow interrupt wakes only from idle sleep.
// - Stop flag sets on a two-wire stop condition, write-one clears, no interrupt.
// - Collision bit reads one when the MSB differs from the data pin level.
// - Counter is CPU readable and writable and counts selected clocks.
// - External source with software clock bit set: toggle strobe writes clock.
// - A pending start or overflow flag requests its interrupt as soon as both enables are set.
// - Wire mode zero disables outputs, clock hold and start detector.
// - Second two-wire mode also holds the clock low after overflow.
module ussc_core
    import ussc_pkg::*;
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic RSTN,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Timer compare match pulse, same clock domain
    input wire logic TIMER_MATCH,
    // Serial clock pin
    input wire logic SCL_I,
    output logic SCL_O,
    output logic SCL_OE_N,
    // Serial data in / two-wire data pin
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_N,
    // Three-wire data out pin
    output logic DO_O,
    output logic DO_OE_N,
    // Interrupt requests and wake
    output logic START_IRQ,
    output logic OVF_IRQ,
    output logic WAKE_DEEP
);
    ussc_ctrl_t ctrl_q;
    ussc_port_t port_q;
    logic soft_ext_q;
    logic [7:0] data_q;
    logic [7:0] data_d;
    logic [7:0] buf_q;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic start_flag_q;
    logic ovf_flag_q;
    logic stop_flag_q;
    logic start_hold_q;
    logic latch_q;
    logic open_q;
    logic [1:0] pin_m_q;
    logic [1:0] pin_s_q;
    logic [1:0] pin_p_q;
    logic clk_prev_q;
    logic [31:0] prdata_q;
    logic slverr_q;
    logic scl_s;
    logic sda_s;
    logic two_wire;
    logic clk_lvl;
    logic ext_edge;
    logic sample_edge;
    logic sw_clk;
    logic tick_cnt;
    logic tick_shift;
    logic overflow;
    logic start_cond;
    logic stop_cond;
    logic out_bit;
    logic hold_scl;
    logic wr;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_data;
    logic wr_port;
    logic [7:0] addr_ctrl;
    logic [7:0] addr_stat;
    logic [7:0] addr_data;
    logic [7:0] addr_buf;
    logic [7:0] addr_port;
    logic [7:0] rd_val;
    logic rd_err;

    // Byte addresses from register indices
    assign addr_ctrl = 8'(`USSC_IDX_CTRL * 4);
    assign addr_stat = 8'(`USSC_IDX_STAT * 4);
    assign addr_data = 8'(`USSC_IDX_DATA * 4);
    assign addr_buf = 8'(`USSC_IDX_BUF * 4);
    assign addr_port = 8'(`USSC_IDX_PORT * 4);

    // Write strobes in the APB access phase
    assign wr = PSEL & PENABLE & PWRITE;
    assign wr_ctrl = wr & (PADDR == addr_ctrl);
    assign wr_stat = wr & (PADDR == addr_stat);
    assign wr_data = wr & (PADDR == addr_data);
    assign wr_port = wr & (PADDR == addr_port);

    // Two-flop synchronisers for clock and data pins, plus a history stage
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            pin_m_q <= 2'h3;
            pin_s_q <= 2'h3;
            pin_p_q <= 2'h3;
        end else begin
            pin_m_q <= {SCL_I, SDA_I};
            pin_s_q <= pin_m_q;
            pin_p_q <= pin_s_q;
        end
    end
    assign scl_s = pin_s_q[1];
    assign sda_s = pin_s_q[0];
    assign two_wire = ctrl_q.wire_mode_select[1];

    // Line conditions seen on synchronised pins, detector active only in two-wire
    assign start_cond = two_wire & scl_s & pin_p_q[1] & pin_p_q[0] & !sda_s;
    assign stop_cond = two_wire & scl_s & pin_p_q[1] & !pin_p_q[0] & sda_s;

    // Clock level: the pin, or the port clock bit when toggle strobes clock
    assign clk_lvl = soft_ext_q ? port_q.scl_out : scl_s;
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            clk_prev_q <= 1'b1;
        end else begin
            clk_prev_q <= clk_lvl;
        end
    end
    // Every edge is seen as long as the pin is no faster than MCLK/2
    assign ext_edge = clk_lvl != clk_prev_q;
    assign sample_edge = ext_edge & (clk_lvl ^ ctrl_q.clock_source_select[0]);

    // Software strobe clocks when the written clock source is software
    assign sw_clk = wr_ctrl & PWDATA[`USSC_CTRL_CLK] &
        (PWDATA[`USSC_CTRL_CS1:`USSC_CTRL_CS0] == 2'h0);

    // Clock source selection for counter and shifter
    always_comb begin
        if (ctrl_q.clock_source_select[1]) begin
            tick_cnt = ext_edge;
            tick_shift = sample_edge;
        end else if (ctrl_q.clock_source_select[0]) begin
            tick_cnt = TIMER_MATCH;
            tick_shift = TIMER_MATCH;
        end else begin
            tick_cnt = sw_clk;
            tick_shift = sw_clk;
        end
    end

    // Counter next value and overflow
    assign overflow = tick_cnt & (cnt_q == `USSC_CNT_MAX);
    always_comb begin
        cnt_d = cnt_q;
        if (wr_stat) begin
            cnt_d = PWDATA[`USSC_STAT_CNT_HI:0];
        end else if (tick_cnt) begin
            cnt_d = cnt_q + 4'h1;
        end
    end

    // Shift register next value, CPU write beats a shift in the same cycle
    always_comb begin
        data_d = data_q;
        if (wr_data) begin
            data_d = PWDATA[7:0];
        end else if (tick_shift) begin
            data_d = {data_q[6:0], sda_s};
        end
    end

    // Counter, data register and completion buffer
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            cnt_q <= 4'h0;
            data_q <= `USSC_RST_DATA;
            buf_q <= `USSC_RST_DATA;
        end else begin
            cnt_q <= cnt_d;
            data_q <= data_d;
            if (overflow) begin
                buf_q <= data_d;
            end
        end
    end

    // Control register; clock strobe bit selects toggle clocking under external source
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl_q <= ussc_ctrl_t'(6'(`USSC_RST_CTRL >> 2));
            soft_ext_q <= 1'b0;
        end else if (wr_ctrl) begin
            ctrl_q <= ussc_ctrl_t'(PWDATA[7:2]);
            soft_ext_q <= PWDATA[`USSC_CTRL_CS1] & PWDATA[`USSC_CTRL_CLK];
        end
    end

    // Port bits; the toggle strobe flips the clock output bit
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            port_q <= ussc_port_t'(7'(`USSC_RST_PORT));
        end else if (wr_port) begin
            port_q <= ussc_port_t'(PWDATA[6:0]);
        end else if (wr_ctrl & PWDATA[`USSC_CTRL_TC]) begin
            port_q.scl_out <= !port_q.scl_out;
        end
    end

    // Status flags: hardware set wins over the write-one clear
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            start_flag_q <= 1'b0;
            ovf_flag_q <= 1'b0;
            stop_flag_q <= 1'b0;
        end else begin
            if (two_wire ? start_cond : ext_edge) begin
                start_flag_q <= 1'b1;
            end else if (wr_stat & PWDATA[`USSC_STAT_SIF]) begin
                start_flag_q <= 1'b0;
            end
            if (overflow) begin
                ovf_flag_q <= 1'b1;
            end else if (wr_stat & PWDATA[`USSC_STAT_OIF]) begin
                ovf_flag_q <= 1'b0;
            end
            if (stop_cond) begin
                stop_flag_q <= 1'b1;
            end else if (wr_stat & PWDATA[`USSC_STAT_PF]) begin
                stop_flag_q <= 1'b0;
            end
        end
    end

    // Start hold engages at the clock falling edge after a start, ends with the flag
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            start_hold_q <= 1'b0;
        end else if (!start_flag_q || !two_wire) begin
            start_hold_q <= 1'b0;
        end else if (pin_p_q[1] & !scl_s) begin
            start_hold_q <= 1'b1;
        end
    end

    // Output latch: opens at the change edge, closes holding the MSB at the sample edge
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            open_q <= 1'b1;
            latch_q <= 1'b1;
        end else if (sample_edge) begin
            open_q <= 1'b0;
            latch_q <= data_q[7];
        end else if (ext_edge) begin
            open_q <= 1'b1;
        end
    end
    assign out_bit = (!ctrl_q.clock_source_select[1] | open_q) ? data_q[7] : latch_q;

    // Clock hold on the open-drain clock line
    // Gated by two-wire so a stale start hold never outlives a mode change
    assign hold_scl = two_wire & (start_hold_q |
        (ctrl_q.wire_mode_select == USSC_WM_TWO_HOLD & ovf_flag_q));

    // Pin drivers; wire mode zero leaves the pins to the port bits
    always_comb begin
        DO_O = port_q.do_out;
        DO_OE_N = !port_q.do_dir;
        SDA_O = port_q.sda_out;
        SDA_OE_N = !port_q.sda_dir;
        SCL_O = port_q.scl_out;
        SCL_OE_N = !port_q.scl_dir;
        if (ctrl_q.wire_mode_select == USSC_WM_THREE) begin
            DO_O = out_bit;
        end else if (two_wire) begin
            SDA_O = 1'b0;
            SDA_OE_N = !(port_q.sda_dir & (!out_bit | !port_q.sda_out));
            SCL_O = 1'b0;
            SCL_OE_N = !(port_q.scl_dir & (hold_scl | !port_q.scl_out));
        end
    end

    // Interrupt requests follow pending flags at once; only start wakes deep sleep
    assign START_IRQ = start_flag_q & ctrl_q.start_irq_enable & port_q.gie;
    assign OVF_IRQ = ovf_flag_q & ctrl_q.overflow_irq_enable & port_q.gie;
    assign WAKE_DEEP = START_IRQ;

    // Read mux, decoded in the setup phase
    always_comb begin
        rd_val = 8'h00;
        rd_err = 1'b0;
        if (PADDR == addr_ctrl) begin
            rd_val = {ctrl_q, 2'h0};
        end else if (PADDR == addr_stat) begin
            rd_val = {start_flag_q, ovf_flag_q, stop_flag_q, data_q[7] != sda_s, cnt_q};
        end else if (PADDR == addr_data) begin
            rd_val = data_q;
        end else if (PADDR == addr_buf) begin
            rd_val = buf_q;
        end else if (PADDR == addr_port) begin
            rd_val = {1'b0, port_q};
        end else begin
            rd_err = 1'b1;
        end
    end

    // Read data and error captured for the access phase
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            prdata_q <= 32'h0;
            slverr_q <= 1'b0;
        end else if (PSEL & !PENABLE) begin
            prdata_q <= PWRITE ? 32'h0 : {24'h0, rd_val};
            slverr_q <= rd_err;
        end
    end
    assign PRDATA = prdata_q;
    assign PSLVERR = slverr_q & PSEL & PENABLE;
    assign PREADY = 1'b1;

    // Checks
    property p_start_off;
        @(posedge MCLK) disable iff (!RSTN)
            (!two_wire && !ext_edge && !start_flag_q) |=> !start_flag_q;
    endproperty
    a_start_off: assert property (p_start_off) else $error("start seen outside two-wire");

    property p_cnt_inc;
        @(posedge MCLK) disable iff (!RSTN) (tick_cnt & !wr_stat) |=> cnt_q == $past(cnt_q) + 4'h1;
    endproperty
    a_cnt_inc: assert property (p_cnt_inc) else $error("counter missed a tick");

    property p_write_wins;
        @(posedge MCLK) disable iff (!RSTN) wr_data |=> data_q == $past(PWDATA[7:0]);
    endproperty
    a_write_wins: assert property (p_write_wins) else $error("written data lost");

    property p_shift;
        @(posedge MCLK) disable iff (!RSTN)
            (tick_shift & !wr_data) |=> data_q[7:1] == $past(data_q[6:0]);
    endproperty
    a_shift: assert property (p_shift) else $error("shift missed");

    property p_buf;
        @(posedge MCLK) disable iff (!RSTN) overflow |=> buf_q == data_q && ovf_flag_q;
    endproperty
    a_buf: assert property (p_buf) else $error("buffer not loaded on overflow");

    property p_start_hold_rel;
        @(posedge MCLK) disable iff (!RSTN) !start_flag_q |=> !start_hold_q;
    endproperty
    a_start_hold_rel: assert property (p_start_hold_rel) else $error("hold after clear");

    property p_ovf_hold;
        @(posedge MCLK) disable iff (!RSTN)
            (ctrl_q.wire_mode_select == USSC_WM_TWO_HOLD && ovf_flag_q && port_q.scl_dir)
            |-> !SCL_OE_N && !SCL_O;
    endproperty
    a_ovf_hold: assert property (p_ovf_hold) else $error("overflow hold not driven");

    property p_irq;
        @(posedge MCLK) disable iff (!RSTN)
            $rose(ctrl_q.overflow_irq_enable) && ovf_flag_q && port_q.gie |-> OVF_IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("pending overflow not requested");

    property p_off_pins;
        @(posedge MCLK) disable iff (!RSTN)
            ctrl_q.wire_mode_select == USSC_WM_OFF |-> DO_O == port_q.do_out && !hold_scl;
    endproperty
    a_off_pins: assert property (p_off_pins) else $error("outputs active in mode zero");
endmodule

// [tb/ussc_link_model.sv]
// Far-side serial bus master that drives the clock and data lines
`timescale 1ns/10ps
module ussc_link_model (
    // Pacing clock
    input wire logic clk,
    // Levels driven, one means released to the pull-up
    output logic scl,
    output logic sda
);
    localparam int HALF = 4;
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // Half of the 160 ns link period, well below half the system clock rate
    task automatic half();
        repeat (HALF) @(posedge clk);
    endtask
    // Byte MSB first from an idle-high clock: data changes on the falling edge,
    // is sampled on the rising edge; 16 edges, clock left standing high
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            scl <= 1'b0;
            sda <= b[i];
            half();
            scl <= 1'b1;
            half();
        end
    endtask
    // Both lines released, clock standing high
    task automatic bus_idle();
        scl <= 1'b1;
        sda <= 1'b1;
        half();
    endtask
    // Data falls while clock high, then the clock is pulled low
    task automatic start_cond();
        sda <= 1'b0;
        half();
        scl <= 1'b0;
        half();
    endtask
    // Release the clock line; the slave may still hold it low
    task automatic release_clk();
        scl <= 1'b1;
        half();
    endtask
    // Data driven to a level for one half period
    task automatic set_sda(input logic v);
        sda <= v;
        half();
    endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench of the serial shift core
`timescale 1ns/10ps
`include "ussc_defs.svh"
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin num_errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end
module testbench;
    logic MCLK = 1'b0;
    logic RSTN = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic TIMER_MATCH = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic PREADY, PSLVERR, SCL_O, SCL_OE_N, SDA_O, SDA_OE_N, DO_O, DO_OE_N;
    logic START_IRQ, OVF_IRQ, WAKE_DEEP, lm_scl, lm_sda, scl_w, sda_w, err;
    logic [7:0] rd, b;
    logic [7:0] sent_q[$];
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    // Open-drain wires resolved from both parties
    assign scl_w = lm_scl & (SCL_OE_N | SCL_O);
    assign sda_w = lm_sda & (SDA_OE_N | SDA_O);
    always #10 MCLK = ~MCLK;
    ussc_core i_dut (.MCLK(MCLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .TIMER_MATCH(TIMER_MATCH),
        .SCL_I(scl_w), .SCL_O(SCL_O), .SCL_OE_N(SCL_OE_N), .SDA_I(sda_w),
        .SDA_O(SDA_O), .SDA_OE_N(SDA_OE_N), .DO_O(DO_O), .DO_OE_N(DO_OE_N),
        .START_IRQ(START_IRQ), .OVF_IRQ(OVF_IRQ), .WAKE_DEEP(WAKE_DEEP));
    ussc_link_model i_link (.clk(MCLK), .scl(lm_scl), .sda(lm_sda));
    // Cut a hang short
    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            final_report();
        end
    end
    // One APB transfer; tm raises the timer match during the access phase
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       input logic tm = 1'b0);
        @(posedge MCLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= idx << 2;
        PWDATA <= {24'h0, wd};
        @(posedge MCLK);
        PENABLE <= 1'b1;
        TIMER_MATCH <= tm;
        do begin
            @(posedge MCLK);
        end while (PREADY !== 1'b1);
        rd = PRDATA[7:0];
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        TIMER_MATCH <= 1'b0;
    endtask
    task automatic final_report();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(16607));
        repeat (16) @(posedge MCLK);
        RSTN <= 1'b1;
        // Reset values and an unmapped word
        apb(0, `USSC_IDX_CTRL, 0);
        `CHK("ctrl", `USSC_RST_CTRL, rd)
        apb(0, `USSC_IDX_STAT, 0);
        `CHK("stat", `USSC_RST_STAT, rd & 8'hef)
        apb(0, `USSC_IDX_PORT, 0);
        `CHK("port", `USSC_RST_PORT, rd)
        `CHK("sda_o", 1'b1, SDA_O)
        apb(0, 8'h20, 0);
        `CHK("slverr", 1'b1, err)
        `CHK("unmapped", 8'h00, rd)
        // Three-wire, timer clock: open latch, direction, write beats shift
        apb(1, `USSC_IDX_PORT, 8'h67);
        apb(1, `USSC_IDX_CTRL, 8'h14);
        apb(1, `USSC_IDX_STAT, 8'hf0);
        apb(1, `USSC_IDX_DATA, 8'h80);
        @(posedge MCLK);
        `CHK("do_o", 1'b1, DO_O)
        `CHK("do_oe_n", 1'b0, DO_OE_N)
        b = 8'($urandom_range(0, 127));
        apb(1, `USSC_IDX_DATA, b, 1'b1);
        @(posedge MCLK);
        `CHK("do_o", 1'b0, DO_O)
        apb(0, `USSC_IDX_DATA, 0);
        `CHK("data", b, rd)
        @(posedge MCLK);
        TIMER_MATCH <= 1'b1;
        @(posedge MCLK);
        TIMER_MATCH <= 1'b0;
        apb(0, `USSC_IDX_DATA, 0);
        `CHK("data", {b[6:0], 1'b1}, rd)
        apb(0, `USSC_IDX_STAT, 0);
        `CHK("count", 8'h02, rd & 8'h0f)
        apb(1, `USSC_IDX_PORT, 8'h47);
        @(posedge MCLK);
        `CHK("do_oe_n", 1'b1, DO_OE_N)
        // Outputs off, external clock: byte shifted in on 16 edges
        apb(1, `USSC_IDX_CTRL, 8'h08);
        apb(1, `USSC_IDX_STAT, 8'hf0);
        b = 8'($urandom_range(0, 255));
        sent_q.push_back(b);
        i_link.send_byte(b);
        apb(0, `USSC_IDX_STAT, 0);
        `CHK("ovf_cnt", 8'h40, rd & 8'h4f)
        `CHK("start", 1'b1, rd[7])
        apb(0, `USSC_IDX_DATA, 0);
        `CHK("data", sent_q[0], rd)
        apb(0, `USSC_IDX_BUF, 0);
        `CHK("buffer", sent_q[0], rd)
        void'(sent_q.pop_front());
        `CHK("ovf_irq", 1'b0, OVF_IRQ)
        apb(1, `USSC_IDX_CTRL, 8'h48);
        @(posedge MCLK);
        `CHK("ovf_irq", 1'b1, OVF_IRQ)
        apb(1, `USSC_IDX_STAT, 8'hc0);
        @(posedge MCLK);
        `CHK("ovf_irq", 1'b0, OVF_IRQ)
        // Toggle-strobe clocking under external source, falling sample edge
        apb(1, `USSC_IDX_CTRL, 8'h0f);
        apb(1, `USSC_IDX_CTRL, 8'h0f);
        apb(0, `USSC_IDX_STAT, 0);
        `CHK("toggle_cnt", 8'h02, rd & 8'h0f)
        apb(0, `USSC_IDX_DATA, 0);
        `CHK("toggle_data", {b[6:0], b[0]}, rd)
        // Two-wire with overflow hold, counter preloaded to F
        i_link.bus_idle();
        apb(1, `USSC_IDX_DATA, 8'hff);
        apb(1, `USSC_IDX_PORT, 8'h5f);
        apb(1, `USSC_IDX_CTRL, 8'h30);
        apb(1, `USSC_IDX_STAT, 8'hef);
        apb(1, `USSC_IDX_CTRL, 8'h72);
        repeat (2) @(posedge MCLK);
        `CHK("scl_oe_n", 1'b0, SCL_OE_N)
        `CHK("scl_o", 1'b0, SCL_O)
        `CHK("sda_oe_n", 1'b1, SDA_OE_N)
        `CHK("ovf_irq", 1'b1, OVF_IRQ)
        `CHK("wake_deep", 1'b0, WAKE_DEEP)
        apb(0, `USSC_IDX_STAT, 0);
        `CHK("ovf_cnt", 8'h40, rd & 8'h4f)
        apb(1, `USSC_IDX_STAT, 8'h40);
        repeat (2) @(posedge MCLK);
        `CHK("scl_oe_n", 1'b1, SCL_OE_N)
        // Two-wire start condition, clock hold, stop condition
        apb(1, `USSC_IDX_CTRL, 8'ha0);
        i_link.start_cond();
        `CHK("start_irq", 1'b1, START_IRQ)
        `CHK("wake_deep", 1'b1, WAKE_DEEP)
        i_link.release_clk();
        `CHK("scl_line", 1'b0, scl_w)
        apb(0, `USSC_IDX_STAT, 0);
        `CHK("start", 1'b1, rd[7])
        apb(1, `USSC_IDX_STAT, 8'h80);
        repeat (2) @(posedge MCLK);
        `CHK("scl_oe_n", 1'b1, SCL_OE_N)
        `CHK("start_irq", 1'b0, START_IRQ)
        i_link.set_sda(1'b1);
        apb(0, `USSC_IDX_STAT, 0);
        `CHK("stop", 1'b1, rd[5])
        `CHK("start_irq", 1'b0, START_IRQ)
        apb(1, `USSC_IDX_STAT, 8'h20);
        apb(0, `USSC_IDX_STAT, 0);
        `CHK("stop", 1'b0, rd[5])
        // Collision: MSB one while the partner pulls data low
        i_link.set_sda(1'b0);
        apb(0, `USSC_IDX_STAT, 0);
        `CHK("collision", 1'b1, rd[4])
        i_link.set_sda(1'b1);
        apb(0, `USSC_IDX_STAT, 0);
        `CHK("collision", 1'b0, rd[4])
        final_report();
    end
endmodule
